// ==== tss_defines.vh ====
/*
 Constants for the transmission status signal encoder: register offsets,
 field positions, reset values and update periods.
 Assumes a 40 MHz clock; included by tss_encoder.v.
*/
`ifndef TSS_DEFINES_VH
`define TSS_DEFINES_VH

// =====================================================================
// Clock and update timing
`define TSS_CLK_HZ 40000000
`define TSS_SLOW_MS 1025
`define TSS_PERF_MS 125
`define TSS_LOCK_MS 100
`define TSS_SLOW_CYC ((`TSS_SLOW_MS * (`TSS_CLK_HZ / 1000)))
`define TSS_PERF_CYC ((`TSS_PERF_MS * (`TSS_CLK_HZ / 1000)))
`define TSS_LOCK_CYC ((`TSS_LOCK_MS * (`TSS_CLK_HZ / 1000)))

// =====================================================================
// Register byte offsets
`define TSS_REG_CTRL 8'h00
`define TSS_REG_OIL_EST 8'h04
`define TSS_REG_TEMP_IN 8'h08
`define TSS_REG_STATUS 8'h0C

// =====================================================================
// Control register fields
`define TSS_CTRL_SENSOR_FAIL 0
`define TSS_CTRL_BACKUP_OK 1
`define TSS_CTRL_PERF_ACTIVE 2
`define TSS_CTRL_NOT_WORKING 3
`define TSS_CTRL_SKIP_COND 4
`define TSS_CTRL_RESET_VAL 8'h00

// =====================================================================
// Status register fields
`define TSS_STAT_OIL_LO 0
`define TSS_STAT_TEMP_LO 8
`define TSS_STAT_TEMP_BAD 16
`define TSS_STAT_PERF 17
`define TSS_STAT_LOCK 18
`define TSS_STAT_SKIP 19
`define TSS_STAT_RESET_REQ 20

// =====================================================================
// Values
`define TSS_OIL_FULL 8'hFF
`define TSS_TEMP_RESET 8'h28

`endif

// ==== tss_encoder.v ====
/*
 Transmission status signal encoder: software writes the controller's
 estimates and conditions over classic Wishbone; the block drives the
 serial network fields at their update rates and handles oil-life reset.
 Assumes a single 40 MHz clock and inputs synchronous to it.
*/
// Notes on behaviour
// - Oil remaining life is 8-bit unsigned, 0.392157 percent per count.
// - A reset request restores the oil life estimate to full.
// - Reported oil life follows the estimate within 1025 ms.
// - Fluid temperature is 8-bit count, degrees equal count minus 40.
// - Validity flag is 1 when sensor failed without backup, else 0.
// - Reported temperature follows sensed value within 1025 ms.
// - Performance shift flag true while algorithm active, within 125 ms.
// - Lever lock true while not working, within 100 ms, true at power-up.
// - Skip-shift true while upshift inhibited, updated within 1025 ms.
`timescale 1ns/1ps
`default_nettype none
`include "tss_defines.vh"

module tss_encoder #(
    parameter integer SLOW_CYC = `TSS_SLOW_CYC,
    parameter integer PERF_CYC = `TSS_PERF_CYC,
    parameter integer LOCK_CYC = `TSS_LOCK_CYC
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    input wire oil_reset_req_i,
    output reg [7:0] oil_life_o,
    output reg [7:0] oil_temp_o,
    output reg oil_temp_invalid_o,
    output reg perf_shift_o,
    output reg lever_lock_req_o,
    output reg skip_shift_o
);

    // =================================================================
    // Cycle counter helper
    function [31:0] tss_tick;
        input [31:0] cnt;
        input integer lim;
        begin
            if (cnt >= lim - 1) begin
                tss_tick = 32'h0000_0000;
            end else begin
                tss_tick = cnt + 32'h0000_0001;
            end
        end
    endfunction

    // =================================================================
    // Registers
    reg [7:0] ctrl;
    reg [7:0] oil_est;
    reg [7:0] temp_in;
    reg reset_req_d;
    reg [31:0] slow_cnt;
    reg [31:0] perf_cnt;
    reg [31:0] lock_cnt;

    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire wr = req & wb_we_i;
    wire reset_edge = oil_reset_req_i & ~reset_req_d;
    wire hit = (wb_adr_i == `TSS_REG_CTRL) | (wb_adr_i == `TSS_REG_OIL_EST) |
        (wb_adr_i == `TSS_REG_TEMP_IN) | (wb_adr_i == `TSS_REG_STATUS);
    wire slow_due = (slow_cnt >= SLOW_CYC - 1);
    wire perf_due = (perf_cnt >= PERF_CYC - 1);
    wire lock_due = (lock_cnt >= LOCK_CYC - 1);
    wire temp_bad = ctrl[`TSS_CTRL_SENSOR_FAIL] &
        ~ctrl[`TSS_CTRL_BACKUP_OK];

    // =================================================================
    // Wishbone slave: registered ack after one wait state, err on unmapped address
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & hit;
            wb_err_o <= req & ~hit;
            if (req) begin
                case (wb_adr_i)
                    `TSS_REG_CTRL: wb_dat_o <= {24'h000000, ctrl};
                    `TSS_REG_OIL_EST: wb_dat_o <= {24'h000000, oil_est};
                    `TSS_REG_TEMP_IN: wb_dat_o <= {24'h000000, temp_in};
                    `TSS_REG_STATUS: wb_dat_o <= {11'h000,
                        oil_reset_req_i, skip_shift_o, lever_lock_req_o,
                        perf_shift_o, oil_temp_invalid_o, oil_temp_o,
                        oil_life_o};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // =================================================================
    // Software-written inputs and oil-life estimate
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `TSS_CTRL_RESET_VAL;
            oil_est <= `TSS_OIL_FULL;
            temp_in <= `TSS_TEMP_RESET;
            reset_req_d <= 1'b0;
        end else begin
            reset_req_d <= oil_reset_req_i;
            if (wr & wb_sel_i[0] & (wb_adr_i == `TSS_REG_CTRL)) begin
                ctrl <= wb_dat_i[7:0];
            end
            if (wr & wb_sel_i[0] & (wb_adr_i == `TSS_REG_TEMP_IN)) begin
                temp_in <= wb_dat_i[7:0];
            end
            if (reset_edge) begin
                oil_est <= `TSS_OIL_FULL;
            end else if (wr & wb_sel_i[0] &
                    (wb_adr_i == `TSS_REG_OIL_EST)) begin
                oil_est <= wb_dat_i[7:0];
            end
        end
    end

    // =================================================================
    // Periodic refresh of the transmitted fields
    always @(posedge clk_i) begin
        if (rst_i) begin
            slow_cnt <= 32'h0000_0000;
            perf_cnt <= 32'h0000_0000;
            lock_cnt <= 32'h0000_0000;
            oil_life_o <= `TSS_OIL_FULL;
            oil_temp_o <= `TSS_TEMP_RESET;
            oil_temp_invalid_o <= 1'b0;
            perf_shift_o <= 1'b0;
            lever_lock_req_o <= 1'b1;
            skip_shift_o <= 1'b0;
        end else begin
            slow_cnt <= tss_tick(slow_cnt, SLOW_CYC);
            perf_cnt <= tss_tick(perf_cnt, PERF_CYC);
            lock_cnt <= tss_tick(lock_cnt, LOCK_CYC);
            if (slow_due) begin
                oil_life_o <= oil_est;
                oil_temp_o <= temp_in;
                oil_temp_invalid_o <= temp_bad;
                skip_shift_o <= ctrl[`TSS_CTRL_SKIP_COND];
            end
            if (perf_due) begin
                perf_shift_o <= ctrl[`TSS_CTRL_PERF_ACTIVE];
            end
            if (lock_due) begin
                lever_lock_req_o <= ctrl[`TSS_CTRL_NOT_WORKING];
            end
        end
    end

endmodule // tss_encoder

`default_nettype wire

// ==== tss_checker_sva.sv ====
/* Checker for the status encoder ports.
 Assumes the short slow refresh period SLOW_CYC handed on by the bind. */
`timescale 1ns/1ps
`default_nettype none
module tss_checker #(parameter integer SLOW_CYC = 40) (
    input wire clk_i, input wire rst_i,
    input wire wb_cyc_i, input wire wb_stb_i,
    input wire [7:0] wb_adr_i,
    input wire wb_ack_o, input wire wb_err_o,
    input wire oil_reset_req_i,
    input wire [7:0] oil_life_o, input wire [7:0] oil_temp_o,
    input wire perf_shift_o, input wire lever_lock_req_o
);
    localparam int SL = SLOW_CYC + 2;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    a_ack_mapped: assert property (s_req ##0 wb_adr_i inside
        {8'h00, 8'h04, 8'h08, 8'h0C} |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acked");
    a_err_unmapped: assert property (s_req ##0 wb_adr_i > 8'h0C
        |=> wb_err_o && !wb_ack_o) else $error("unmapped access not refused");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_reset_values: assert property ($fell(rst_i) |->
        lever_lock_req_o && oil_life_o == 8'hFF && oil_temp_o == 8'h28)
        else $error("bad reset");
    a_oil_renew: assert property ($rose(oil_reset_req_i) |->
        ##[1:SL] oil_life_o == 8'hFF) else $error("oil life not renewed");
    a_life_hold: assert property ($changed(oil_life_o) |=>
        $stable(oil_life_o)[*8]) else $error("oil life refreshed early");
    a_temp_hold: assert property ($changed(oil_temp_o) |=>
        $stable(oil_temp_o)[*8]) else $error("temperature refreshed early");
    a_perf_hold: assert property ($changed(perf_shift_o) |=>
        $stable(perf_shift_o)[*8]) else $error("perf flag refreshed early");
    a_lock_hold: assert property ($changed(lever_lock_req_o) |=>
        $stable(lever_lock_req_o)[*7]) else $error("lock refreshed early");
endmodule // tss_checker
bind tss_encoder tss_checker #(.SLOW_CYC(SLOW_CYC)) tss_checker_inst (.*);
`default_nettype wire

// ==== tss_platform.sv ====
/* Platform model: drives the oil-life reset request, shows the fluid
 temperature and holds the gear lever.
 Assumes press and loss inputs change after clock edges. */
`timescale 1ns/1ps
`default_nettype none
module tss_platform (
    input wire logic clk_i,
    input wire logic press_i,
    input wire logic lost_i,
    input wire logic [7:0] temp_i,
    input wire logic temp_invalid_i,
    input wire logic lock_req_i,
    output logic req_o,
    output logic [7:0] shown_temp_o,
    output logic lever_held_o
);
    always @(posedge clk_i) begin
        req_o <= press_i && !lost_i;
        if (!temp_invalid_i) begin
            shown_temp_o <= temp_i;
        end
        lever_held_o <= lock_req_i;
    end
endmodule // tss_platform
`default_nettype wire

// ==== tb_top.sv ====
/* Self-checking bench for the status encoder.
 Assumes the encoder, its bound checker and the platform model. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic press = 0, lost = 0, er;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    wire [31:0] dat_o;
    wire ack, err, req, inv, perf, lock, skip;
    wire [7:0] life, temp, shown;
    wire held;
    int n_fail = 0, check_count = 0;
    always #12.5 clk_i = ~clk_i;
    tss_encoder #(.SLOW_CYC(40), .PERF_CYC(10), .LOCK_CYC(8))
        tss_encoder_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
        .oil_reset_req_i(req), .oil_life_o(life), .oil_temp_o(temp),
        .oil_temp_invalid_o(inv), .perf_shift_o(perf),
        .lever_lock_req_o(lock), .skip_shift_o(skip));
    tss_platform tss_platform_inst (.clk_i(clk_i), .press_i(press),
        .lost_i(lost), .temp_i(temp), .temp_invalid_i(inv),
        .lock_req_i(lock), .req_o(req), .shown_temp_o(shown),
        .lever_held_o(held));
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (!(ack || err) && ++k < 20);
        if (k >= 20) begin
            n_fail++;
            wrap_up;
        end
        rdat = dat_o;
        er = err;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    task automatic outs(input logic [31:0] x);
        chk("outputs", x, {11'h0, req, skip, lock, perf, inv, temp, life});
        bus(0, 8'h0C, 0);
        chk("status", x, rdat);
    endtask
    task automatic t_reset;
        outs(32'h000428FF);
        bus(0, 8'h00, 0);
        chk("ctrl", 0, rdat);
        bus(0, 8'h04, 0);
        chk("oil_est", 32'hFF, rdat);
        bus(0, 8'h08, 0);
        chk("temp_in", 32'h28, rdat);
    endtask
    task automatic t_fields;
        bus(1, 8'h04, 32'h80);
        bus(1, 8'h00, 32'h1D);
        bus(1, 8'h08, 32'h7A);
        wt(44);
        outs(32'h000F7A80);
        chk("shown_temp", 32'h28, shown);
        chk("lever_held", 1, held);
        bus(1, 8'h04, 32'h00);
        bus(1, 8'h08, 32'h00);
        bus(1, 8'h00, 32'h03);
        wt(44);
        outs(32'h00000000);
        chk("shown_temp", 32'h00, shown);
        chk("lever_held", 0, held);
    endtask
    task automatic t_err;
        bus(1, 8'h10, 32'h55);
        chk("err", 1, er);
        bus(0, 8'h04, 0);
        chk("oil_est", 0, rdat);
    endtask
    task automatic t_oil;
        bus(1, 8'h04, 32'h10);
        lost <= 1;
        press <= 1;
        wt(44);
        chk("life_lost", 32'h10, life);
        lost <= 0;
        wt(44);
        chk("life_reset", 32'hFF, life);
        bus(1, 8'h04, 32'h22);
        wt(44);
        chk("life_held", 32'h22, life);
        press <= 0;
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #(25 * 2000);
        n_fail++;
        wrap_up;
    end
    initial begin
        wt(6);
        rst_i <= 0;
        t_reset;
        t_fields;
        t_err;
        t_oil;
        wrap_up;
    end
endmodule // tb_top
`default_nettype wire
